// [rtl/ecl_loader.sv]
// Configuration image loader: memory copy, header decode, bus slave
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ns
`include "ecl_consts.svh"

// Behaviour
// - Present only when first byte is signature
// - Copy whole image into 512-byte memory
// - PHY held disconnected until load finishes
// - Pointers count words; byte address doubled
// - Zero length means item absent, default
// - No strings means no language ID
// - Polling intervals at bytes 01h to 03h
// - Four flag words, little-endian, 04h to 13h
// - Software structure length 14h, offset 15h
// - Pin function bits 20h-23h, 0 is GPIO
// - Driver type 24h-27h, 1 is push-pull
// - Direction 28h-2Bh, 1 is output
// - Data 2Ch-2Fh drives output pins
// - String pairs at 32h through 3Bh
// - BOS, SS device, SS config pairs 3Ch-41h
// - High-speed descriptor pairs at 42h-45h
// - Full-speed descriptor pairs at 46h-49h
// - Nothing fixed at or above 4Ah
// - SS block holds four descriptors in order
module ecl_loader #(
    parameter logic [7:0] DEF_POLL_FS = 8'h01,
    parameter logic [7:0] DEF_POLL_HS = 8'h04,
    parameter logic [7:0] DEF_POLL_SS = 8'h04,
    parameter logic [31:0] DEF_FLAGS = 32'h0,
    parameter logic [31:0] DEF_GPIO_FUNC = 32'hffffffff,
    parameter int SK_HALF = `ECL_SK_HALF
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata_q,
    output logic hreadyout_q,
    output logic hresp_q,
    output logic ee_cs_q,
    output logic ee_sk_q,
    output logic ee_di_q,
    input wire logic ee_do,
    output logic phy_disconnect_q,
    output logic load_done_q,
    output logic present_q,
    input wire logic [8:0] desc_addr,
    output logic [7:0] desc_data_q,
    output ecl_pkg::ecl_cfg_s cfg_q,
    output ecl_pkg::ecl_ptr_s [`ECL_NITEMS-1:0] items_q,
    input wire logic [31:0] gpio_i,
    output logic [31:0] gpio_o_q,
    output logic [31:0] gpio_oe_n_q
);
    import ecl_pkg::*;

    localparam int AW = $clog2(`ECL_MEM_BYTES);

    logic [1:0] rst_sync_q;
    logic rst_i_n;
    logic [7:0] mem [0:`ECL_MEM_BYTES-1];
    ecl_ld_e st_q, st_d;
    logic [AW-1:0] wa_q, wa_d;
    logic start_q, start_d, stop_q, stop_d;
    logic pres_d, phy_d, done_d, bad_len_q, bad_len_d;
    logic rx_vld;
    logic [7:0] rx_byte, desc_data_d;
    ecl_cfg_s cfg_d;
    ecl_ptr_s [`ECL_NITEMS-1:0] items_d;
    logic wr_q, wr_d, reload_q, reload_d;
    logic [7:0] wad_q, wad_d;
    logic [31:0] hrdata_d;
    logic [31:0] gin_s1_q, gin_s2_q, gin_s3_q, gin_f_q, gin_f_d;
    logic [31:0] gm, gpio_o_d, gpio_oe_n_d;

    // Header byte address of item k: software structure first, then the pair table
    function automatic logic [8:0] item_off(input int k);
        return (k == 0) ? `ECL_OFF_SWCFG : `ECL_OFF_PTR_BASE + 9'(2 * (k - 1));
    endfunction

    // Little-endian word from four image bytes
    function automatic logic [31:0] rd32(input logic [8:0] b);
        return {mem[b + 9'h3], mem[b + 9'h2], mem[b + 9'h1], mem[b]};
    endfunction

    function automatic logic len_ok(input logic [7:0] l, input logic [7:0] v);
        return (l == 8'h00) || (l == v);
    endfunction

    // Reset released through two stages so the whole block leaves reset together
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_i_n = rst_sync_q[1];

    ecl_ee_reader #(
        .HALF(SK_HALF)
    ) u_reader (
        .clk(ref_clk),
        .rst_n(rst_i_n),
        .start(start_q),
        .stop(stop_q),
        .byte_vld_q(rx_vld),
        .byte_q(rx_byte),
        .ee_cs_q(ee_cs_q),
        .ee_sk_q(ee_sk_q),
        .ee_di_q(ee_di_q),
        .ee_do(ee_do)
    );

    // Load sequencer
    always_comb begin
        st_d = st_q;
        wa_d = wa_q;
        start_d = 1'b0;
        stop_d = 1'b0;
        pres_d = present_q;
        phy_d = phy_disconnect_q;
        done_d = load_done_q;
        case (st_q)
            LD_START: begin
                start_d = 1'b1;
                wa_d = '0;
                pres_d = 1'b0;
                phy_d = 1'b1;
                done_d = 1'b0;
                st_d = LD_LOAD;
            end
            LD_LOAD: begin
                if (rx_vld) begin
                    if (wa_q == '0 && rx_byte != `ECL_SIG) begin
                        stop_d = 1'b1;
                        st_d = LD_DECODE;
                    end else begin
                        pres_d = 1'b1;
                        wa_d = wa_q + AW'(1);
                        if (wa_q == AW'(`ECL_MEM_BYTES - 1)) begin
                            stop_d = 1'b1;
                            st_d = LD_DECODE;
                        end
                    end
                end
            end
            LD_DECODE: begin
                done_d = 1'b1;
                phy_d = 1'b0;
                st_d = LD_DONE;
            end
            LD_DONE: begin
                // A reload is only taken once the previous image is settled
                if (reload_q) begin
                    st_d = LD_START;
                end
            end
            default: st_d = LD_START;
        endcase
    end

    // Image memory; no reset, filled whole only by a load with the signature, else only byte 0 is written
    always_ff @(posedge ref_clk) begin
        if (st_q == LD_LOAD && rx_vld) begin
            mem[wa_q] <= rx_byte;
        end
    end
    assign desc_data_d = mem[desc_addr];

    // Header decode, done once in the cycle after the copy ends
    always_comb begin
        cfg_d = cfg_q;
        items_d = items_q;
        bad_len_d = bad_len_q;
        if (st_q == LD_DECODE && present_q) begin
            cfg_d.poll_fs = mem[`ECL_OFF_POLL_FS];
            cfg_d.poll_hs = mem[`ECL_OFF_POLL_HS];
            cfg_d.poll_ss = mem[`ECL_OFF_POLL_SS];
            for (int i = 0; i < 4; i++) begin
                cfg_d.flags[i] = rd32(`ECL_OFF_FLAGS + 9'(4 * i));
            end
            cfg_d.gpio_func = rd32(`ECL_OFF_GPIO_FUNC);
            cfg_d.gpio_pp = rd32(`ECL_OFF_GPIO_PP);
            cfg_d.gpio_dir = rd32(`ECL_OFF_GPIO_DIR);
            cfg_d.gpio_data = rd32(`ECL_OFF_GPIO_DATA);
            cfg_d.lang_id = {mem[`ECL_OFF_LANG + 9'h1], mem[`ECL_OFF_LANG]};
            cfg_d.lang_ok = 1'b0;
            // Pairs end at 49h; bytes from 4Ah on are bodies only
            for (int k = 0; k < `ECL_NITEMS; k++) begin
                items_d[k].len = mem[item_off(k)];
                items_d[k].addr = {mem[item_off(k) + 9'h1], 1'b0};
                items_d[k].present = (mem[item_off(k)] != 8'h00);
            end
            for (int s = 1; s <= `ECL_NSTRINGS; s++) begin
                if (mem[item_off(s)] != 8'h00) begin
                    cfg_d.lang_ok = 1'b1;
                end
            end
            // Length check on the SS device, SS config and four HS/FS pairs; a zero length passes
            bad_len_d = !len_ok(mem[item_off(7)], `ECL_LEN_DESC)
                || !len_ok(mem[item_off(8)], `ECL_LEN_SSCFG)
                || !len_ok(mem[item_off(9)], `ECL_LEN_DESC)
                || !len_ok(mem[item_off(10)], `ECL_LEN_DESC)
                || !len_ok(mem[item_off(11)], `ECL_LEN_DESC)
                || !len_ok(mem[item_off(12)], `ECL_LEN_DESC);
        end else if (st_q == LD_DECODE) begin
            cfg_d.poll_fs = DEF_POLL_FS;
            cfg_d.poll_hs = DEF_POLL_HS;
            cfg_d.poll_ss = DEF_POLL_SS;
            cfg_d.flags = {4{DEF_FLAGS}};
            cfg_d.gpio_func = DEF_GPIO_FUNC;
            cfg_d.gpio_pp = 32'h0;
            cfg_d.gpio_dir = 32'h0;
            cfg_d.gpio_data = 32'h0;
            cfg_d.lang_id = 16'h0;
            cfg_d.lang_ok = 1'b0;
            items_d = '0;
            bad_len_d = 1'b0;
        end
    end

    // Pin drive only in GPIO mode as output; open-drain drives low only
    always_comb begin
        gm = {32{load_done_q}} & ~cfg_q.gpio_func & cfg_q.gpio_dir;
        gpio_o_d = gm & cfg_q.gpio_pp & cfg_q.gpio_data;
        gpio_oe_n_d = ~(gm & (cfg_q.gpio_pp | ~cfg_q.gpio_data));
        gin_f_d = (~(gin_s2_q ^ gin_s3_q) & gin_s3_q) | ((gin_s2_q ^ gin_s3_q) & gin_f_q);
    end

    // Bus slave: zero wait states, read data prepared during the address phase
    always_comb begin
        wr_d = hsel && htrans[1] && hready && hwrite;
        wad_d = haddr[7:0];
        reload_d = wr_q && wad_q == `ECL_REG_CTRL && hwdata[0];
        hrdata_d = 32'h0;
        if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                `ECL_REG_STATUS: hrdata_d = {27'h0, bad_len_q, cfg_q.lang_ok,
                    (st_q != LD_DONE), present_q, load_done_q};
                `ECL_REG_POLL: hrdata_d = {8'h0, cfg_q.poll_ss, cfg_q.poll_hs, cfg_q.poll_fs};
                8'h0c, 8'h10, 8'h14, 8'h18: hrdata_d = cfg_q.flags[haddr[3:2] - 2'h3];
                `ECL_REG_SWCFG: hrdata_d = {items_q[0].present, 14'h0, items_q[0].addr,
                    items_q[0].len};
                `ECL_REG_GPIO_FUNC: hrdata_d = cfg_q.gpio_func;
                `ECL_REG_GPIO_PP: hrdata_d = cfg_q.gpio_pp;
                `ECL_REG_GPIO_DIR: hrdata_d = cfg_q.gpio_dir;
                `ECL_REG_GPIO_DATA: hrdata_d = cfg_q.gpio_data;
                `ECL_REG_LANG: hrdata_d = {15'h0, cfg_q.lang_ok, cfg_q.lang_id};
                `ECL_REG_PRESENT: begin
                    for (int k = 0; k < `ECL_NITEMS; k++) begin
                        hrdata_d[k] = items_q[k].present;
                    end
                end
                `ECL_REG_GPIO_IN: hrdata_d = gin_f_q;
                default: hrdata_d = 32'h0;
            endcase
        end
    end

    // All registers of the block except the reset stages and the image memory
    always_ff @(posedge ref_clk or negedge rst_i_n) begin
        if (!rst_i_n) begin
            st_q <= LD_START;
            wa_q <= '0;
            start_q <= 1'b0;
            stop_q <= 1'b0;
            present_q <= 1'b0;
            phy_disconnect_q <= 1'b1;
            load_done_q <= 1'b0;
            bad_len_q <= 1'b0;
            cfg_q <= '0;
            items_q <= '0;
            desc_data_q <= 8'h0;
            wr_q <= 1'b0;
            wad_q <= 8'h0;
            reload_q <= 1'b0;
            hrdata_q <= 32'h0;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            gin_s1_q <= 32'h0;
            gin_s2_q <= 32'h0;
            gin_s3_q <= 32'h0;
            gin_f_q <= 32'h0;
            gpio_o_q <= 32'h0;
            gpio_oe_n_q <= 32'hffffffff;
        end else begin
            st_q <= st_d;
            wa_q <= wa_d;
            start_q <= start_d;
            stop_q <= stop_d;
            present_q <= pres_d;
            phy_disconnect_q <= phy_d;
            load_done_q <= done_d;
            bad_len_q <= bad_len_d;
            cfg_q <= cfg_d;
            items_q <= items_d;
            desc_data_q <= desc_data_d;
            wr_q <= wr_d;
            wad_q <= wad_d;
            reload_q <= reload_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
            gin_s1_q <= gpio_i;
            gin_s2_q <= gin_s1_q;
            gin_s3_q <= gin_s2_q;
            gin_f_q <= gin_f_d;
            gpio_o_q <= gpio_o_d;
            gpio_oe_n_q <= gpio_oe_n_d;
        end
    end

    property p_sig_absent;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_LOAD && rx_vld && wa_q == '0 && rx_byte != `ECL_SIG)
            |=> (st_q == LD_DECODE && !present_q) ##1 (load_done_q && !present_q);
    endproperty
    a_sig_absent: assert property (p_sig_absent) else $error("bad signature not absent");

    property p_copy;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_LOAD && rx_vld) |=> mem[$past(wa_q)] == $past(rx_byte);
    endproperty
    a_copy: assert property (p_copy) else $error("image byte not stored");

    property p_phy;
        @(posedge ref_clk) disable iff (!rst_i_n)
        $fell(phy_disconnect_q) |-> ($past(st_q) == LD_DECODE && load_done_q);
    endproperty
    a_phy: assert property (p_phy) else $error("PHY released before load end");

    property p_word_ptr;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_DECODE && present_q)
            |=> items_q[1].addr == {$past(mem[`ECL_OFF_PTR_BASE + 9'h1]), 1'b0};
    endproperty
    a_word_ptr: assert property (p_word_ptr) else $error("pointer not doubled");

    property p_absent;
        @(posedge ref_clk) disable iff (!rst_i_n)
        load_done_q |-> (items_q[0].present == (items_q[0].len != 8'h00))
            && (items_q[8].present == (items_q[8].len != 8'h00));
    endproperty
    a_absent: assert property (p_absent) else $error("present flag mismatches length");

    property p_lang;
        @(posedge ref_clk) disable iff (!rst_i_n)
        cfg_q.lang_ok |-> (items_q[1].len | items_q[2].len | items_q[3].len
            | items_q[4].len | items_q[5].len) != 8'h00;
    endproperty
    a_lang: assert property (p_lang) else $error("language offered without strings");

    property p_poll;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_DECODE && present_q)
            |=> cfg_q.poll_hs == $past(mem[`ECL_OFF_POLL_HS]);
    endproperty
    a_poll: assert property (p_poll) else $error("polling interval wrong");

    property p_flags;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_DECODE && present_q)
            |=> cfg_q.flags[1][7:0] == $past(mem[9'h008])
                && cfg_q.flags[1][31:24] == $past(mem[9'h00b]);
    endproperty
    a_flags: assert property (p_flags) else $error("flag word byte order wrong");

    property p_gpio_pp;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (load_done_q && !cfg_q.gpio_func[0] && cfg_q.gpio_dir[0] && cfg_q.gpio_pp[0])
            |=> !gpio_oe_n_q[0] && gpio_o_q[0] == $past(cfg_q.gpio_data[0]);
    endproperty
    a_gpio_pp: assert property (p_gpio_pp) else $error("GPIO output not driven");

    property p_defaults;
        @(posedge ref_clk) disable iff (!rst_i_n)
        (st_q == LD_DECODE && !present_q)
            |=> cfg_q.gpio_func == DEF_GPIO_FUNC && items_q == '0 && !cfg_q.lang_ok;
    endproperty
    a_defaults: assert property (p_defaults) else $error("defaults not applied");

endmodule // ecl_loader

// [rtl/ecl_consts.svh]
// Offsets, descriptor lengths and timing counts of the configuration image loader
`ifndef ECL_CONSTS_SVH
`define ECL_CONSTS_SVH

// Image layout, byte addresses inside the serial memory
`define ECL_SIG 8'ha5
`define ECL_MEM_BYTES 512
`define ECL_OFF_SIG 9'h000
`define ECL_OFF_POLL_FS 9'h001
`define ECL_OFF_POLL_HS 9'h002
`define ECL_OFF_POLL_SS 9'h003
`define ECL_OFF_FLAGS 9'h004
`define ECL_OFF_SWCFG 9'h014
`define ECL_OFF_GPIO_FUNC 9'h020
`define ECL_OFF_GPIO_PP 9'h024
`define ECL_OFF_GPIO_DIR 9'h028
`define ECL_OFF_GPIO_DATA 9'h02c
`define ECL_OFF_LANG 9'h030
`define ECL_OFF_PTR_BASE 9'h032
`define ECL_NITEMS 13
`define ECL_NSTRINGS 5
`define ECL_LEN_DESC 8'h12
`define ECL_LEN_SSCFG 8'h1e

// Register bus word offsets
`define ECL_REG_CTRL 8'h00
`define ECL_REG_STATUS 8'h04
`define ECL_REG_POLL 8'h08
`define ECL_REG_FLAGS 8'h0c
`define ECL_REG_SWCFG 8'h1c
`define ECL_REG_GPIO_FUNC 8'h20
`define ECL_REG_GPIO_PP 8'h24
`define ECL_REG_GPIO_DIR 8'h28
`define ECL_REG_GPIO_DATA 8'h2c
`define ECL_REG_LANG 8'h30
`define ECL_REG_PRESENT 8'h34
`define ECL_REG_GPIO_IN 8'h38

// Serial clock timing
`define ECL_CLK_NS 8
`define ECL_SK_PERIOD_NS 160
`define ECL_SK_HALF ((`ECL_SK_PERIOD_NS / `ECL_CLK_NS) / 2)
`define ECL_EE_CMD 12'hc00
`define ECL_EE_CMD_W 12

`endif

// [rtl/ecl_pkg.sv]
// Types shared by the configuration image loader
package ecl_pkg;

    // One length and pointer pair of the image header
    typedef struct packed {
        logic present;
        logic [7:0] len;
        logic [8:0] addr;
    } ecl_ptr_s;

    // Decoded fixed header content
    typedef struct packed {
        logic [7:0] poll_fs;
        logic [7:0] poll_hs;
        logic [7:0] poll_ss;
        logic [3:0][31:0] flags;
        logic [31:0] gpio_func;
        logic [31:0] gpio_pp;
        logic [31:0] gpio_dir;
        logic [31:0] gpio_data;
        logic [15:0] lang_id;
        logic lang_ok;
    } ecl_cfg_s;

    typedef enum logic [1:0] {LD_START, LD_LOAD, LD_DECODE, LD_DONE} ecl_ld_e;
    typedef enum logic [1:0] {RD_IDLE, RD_CMD, RD_DATA} ecl_rd_e;

endpackage

// [rtl/ecl_ee_reader.sv]
// Sequential reader for the 3-wire serial memory
`timescale 1ns/1ns
`include "ecl_consts.svh"

module ecl_ee_reader #(
    parameter int HALF = `ECL_SK_HALF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic stop,
    output logic byte_vld_q,
    output logic [7:0] byte_q,
    output logic ee_cs_q,
    output logic ee_sk_q,
    output logic ee_di_q,
    input wire logic ee_do
);
    import ecl_pkg::*;

    localparam int DW = (HALF > 1) ? $clog2(HALF) : 1;

    ecl_rd_e st_q, st_d;
    logic [DW-1:0] div_q, div_d;
    logic [3:0] cnt_q, cnt_d;
    logic [`ECL_EE_CMD_W-1:0] sh_q, sh_d;
    logic [7:0] rx_q, rx_d, byte_d;
    logic vld_d, cs_d, sk_d, di_d;
    logic do_s1_q, do_s2_q, do_s3_q, do_f_q;

    // Three stages on the data pin; the level counts once the last two agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            do_s1_q <= 1'b0;
            do_s2_q <= 1'b0;
            do_s3_q <= 1'b0;
            do_f_q <= 1'b0;
        end else begin
            do_s1_q <= ee_do;
            do_s2_q <= do_s1_q;
            do_s3_q <= do_s2_q;
            do_f_q <= (do_s2_q == do_s3_q) ? do_s3_q : do_f_q;
        end
    end

    // Command out on the low phase, data sampled at the end of the high phase
    always_comb begin
        st_d = st_q;
        div_d = div_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        rx_d = rx_q;
        byte_d = byte_q;
        vld_d = 1'b0;
        cs_d = ee_cs_q;
        sk_d = ee_sk_q;
        di_d = ee_di_q;
        case (st_q)
            RD_IDLE: begin
                cs_d = 1'b0;
                sk_d = 1'b0;
                di_d = 1'b0;
                if (start) begin
                    st_d = RD_CMD;
                    cs_d = 1'b1;
                    div_d = '0;
                    cnt_d = '0;
                    sh_d = `ECL_EE_CMD;
                    di_d = sh_d[`ECL_EE_CMD_W-1];
                end
            end
            RD_CMD, RD_DATA: begin
                if (stop) begin
                    st_d = RD_IDLE;
                    cs_d = 1'b0;
                    sk_d = 1'b0;
                    di_d = 1'b0;
                end else if (div_q == DW'(HALF - 1)) begin
                    div_d = '0;
                    sk_d = ~ee_sk_q;
                    if (ee_sk_q && st_q == RD_CMD) begin
                        if (cnt_q == 4'(`ECL_EE_CMD_W - 1)) begin
                            st_d = RD_DATA;
                            cnt_d = '0;
                            di_d = 1'b0;
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                            sh_d = {sh_q[`ECL_EE_CMD_W-2:0], 1'b0};
                            di_d = sh_q[`ECL_EE_CMD_W-2];
                        end
                    end else if (ee_sk_q) begin
                        // Bit 0 is the leading dummy zero; bytes then stream MSB first
                        rx_d = {rx_q[6:0], do_f_q};
                        if (cnt_q == 4'h8) begin
                            byte_d = {rx_q[6:0], do_f_q};
                            vld_d = 1'b1;
                            cnt_d = 4'h1;
                        end else begin
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end else begin
                    div_d = div_q + DW'(1);
                end
            end
            default: st_d = RD_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= RD_IDLE;
            div_q <= '0;
            cnt_q <= '0;
            sh_q <= '0;
            rx_q <= '0;
            byte_q <= '0;
            byte_vld_q <= 1'b0;
            ee_cs_q <= 1'b0;
            ee_sk_q <= 1'b0;
            ee_di_q <= 1'b0;
        end else begin
            st_q <= st_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            rx_q <= rx_d;
            byte_q <= byte_d;
            byte_vld_q <= vld_d;
            ee_cs_q <= cs_d;
            ee_sk_q <= sk_d;
            ee_di_q <= di_d;
        end
    end

endmodule // ecl_ee_reader

// [dv/ecl_ee_model.sv]
// Behavioural serial memory that streams the configuration image
`timescale 1ns/1ns
module ecl_ee_model (
    input wire logic ref_clk,
    input wire logic ee_cs,
    input wire logic ee_sk,
    input wire logic ee_di,
    output logic ee_do
);
    logic [7:0] mem [512];
    // Command bits as seen on the data-in line, kept for the bench to inspect
    logic [11:0] cmd = 0;
    logic sk_q = 0;
    int n = 0;
    initial ee_do = 0;
    // Past 12 command bits and the dummy 0, bytes go out MSB first from address 0
    // A released line toggles so a stale level never passes for data
    always @(posedge ref_clk) begin
        sk_q <= ee_sk;
        if (!ee_cs) begin
            n <= 0;
            ee_do <= ~ee_do;
        end else if (ee_sk && !sk_q) begin
            n <= n + 1;
            if (n < 12) cmd <= {cmd[10:0], ee_di};
            if (n > 12) ee_do <= mem[(n - 13) / 8 % 512][7 - (n - 13) % 8];
            else ee_do <= ~ee_do && n != 12;
        end
    end
endmodule  // ecl_ee_model

// [dv/tb_ecl_loader.sv]
// Self-checking bench of the configuration image loader
`timescale 1ns/1ns
module tb_ecl_loader;
    import ecl_pkg::*;
    logic ref_clk = 0, rst_n = 0, hsel = 0, hwrite = 0, hresp_q, hreadyout_q, ee_cs_q, ee_sk_q;
    logic ee_di_q, ee_do, phy_disconnect_q, load_done_q, present_q;
    logic [1:0] htrans = 0;
    logic [8:0] desc_addr = 0;
    logic [7:0] desc_data_q, m [512];
    logic [31:0] haddr = 0, hwdata = 0, gpio_i = 32'h5a5aa5a5, hrdata_q, gpio_o_q, gpio_oe_n_q;
    logic [31:0] r, f, pp, d, dt, ra [15], rx [15];
    ecl_cfg_s cfg_q;
    ecl_ptr_s [12:0] items_q;
    int err_total = 0, n_tests = 0, cyc = 0;
    // Default link clock: 160 ns bit time, ample filter margin on the data line
    ecl_loader ecl_loader_inst (.ref_clk, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout_q), .hrdata_q, .hreadyout_q,
        .hresp_q, .ee_cs_q, .ee_sk_q, .ee_di_q, .ee_do, .phy_disconnect_q, .load_done_q,
        .present_q, .desc_addr, .desc_data_q, .cfg_q, .items_q, .gpio_i, .gpio_o_q,
        .gpio_oe_n_q);
    ecl_ee_model ecl_ee_model_inst (.ref_clk, .ee_cs(ee_cs_q), .ee_sk(ee_sk_q), .ee_di(ee_di_q),
        .ee_do);
    initial forever #4 ref_clk = ~ref_clk;
    // One full load takes about 82k cycles
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            err_total++;
            summarize();
        end
    end
    function automatic logic [31:0] w(int a);
        return {m[a + 3], m[a + 2], m[a + 1], m[a]};
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // Single word transfer; read data taken at the data-phase edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= a;
        do @(posedge ref_clk); while (hreadyout_q !== 1'b1);
        hsel <= 0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout_q !== 1'b1);
        r = hrdata_q;
    endtask
    task automatic wait_done();
        while (load_done_q !== 1'b1) @(posedge ref_clk);
    endtask
    task automatic summarize();
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        for (int i = 0; i < 512; i++) m[i] = i[7:0] ^ 8'h3c;
        m[0] = 8'ha5;
        m[8'h14] = 8'h10;
        m[8'h15] = 8'h30;
        for (int i = 8'h16; i < 8'h20; i++) m[i] = 8'h00;
        for (int k = 0; k < 4; k++) begin
            m[8'h20 + k] = 8'h33;
            m[8'h24 + k] = 8'h55;
            m[8'h28 + k] = 8'h0f;
            m[8'h2c + k] = 8'h06;
        end
        // No strings, so the string pair lengths at 32h to 3Ah are 00h in the image
        for (int k = 8'h32; k < 8'h3c; k += 2) m[k] = 8'h00;
        for (int k = 8'h3e; k < 8'h4a; k += 2) m[k] = k == 8'h40 ? 8'h1e : 8'h12;
        ecl_ee_model_inst.mem = m;
        repeat (4) @(posedge ref_clk);
        chk({gpio_oe_n_q[30:0], phy_disconnect_q}, 32'hffffffff);
        rst_n <= 1;
        repeat (300) @(posedge ref_clk);
        chk({31'h0, phy_disconnect_q}, 32'h1);
        wait_done();
        chk({30'h0, phy_disconnect_q, present_q}, 32'h1);
        chk({20'h0, ecl_ee_model_inst.cmd}, 32'hc00);
        ra = '{4, 8, 12, 16, 20, 24, 28, 32, 36, 40, 44, 48, 52, 56, 60};
        rx = '{32'h3, {8'h0, m[3], m[2], m[1]}, w(4), w(8), w(12), w(16),
            {1'b1, 14'h0, m[8'h15], 1'b0, m[8'h14]}, w(32), w(36), w(40), w(44),
            {16'h0, m[8'h31], m[8'h30]}, 32'h1f81, 32'h5a5aa5a5, 32'h0};
        for (int i = 0; i < 15; i++) begin
            bus(0, ra[i], 0);
            chk(r, rx[i]);
            chk({30'h0, hreadyout_q, hresp_q}, 32'h2);
        end
        chk({14'h0, items_q[8]}, {14'h0, 9'h11e, m[8'h41], 1'b0});
        chk({14'h0, items_q[1]}, {14'h0, 9'h0, m[8'h33], 1'b0});
        f = w(32);
        pp = w(36);
        d = w(40);
        dt = w(44);
        chk(gpio_oe_n_q, ~(~f & d) | (~pp & dt));
        chk(gpio_o_q & ~f & d, ~f & d & pp & dt);
        for (int a = 0; a < 512; a += 74) begin
            @(posedge ref_clk);
            desc_addr <= a[8:0];
            repeat (2) @(posedge ref_clk);
            chk({24'h0, desc_data_q}, {24'h0, m[a]});
        end
        // Reload over a memory without the signature
        ecl_ee_model_inst.mem[0] = 8'h5a;
        bus(1, 0, 1);
        while (load_done_q !== 1'b0) @(posedge ref_clk);
        chk({31'h0, phy_disconnect_q}, 32'h1);
        wait_done();
        bus(0, 4, 0);
        chk(r, 32'h1);
        chk(cfg_q.gpio_func & gpio_oe_n_q, 32'hffffffff);
        chk({23'h0, cfg_q.poll_fs, items_q[8].present}, 32'h2);
        summarize();
    end
endmodule  // tb_ecl_loader
